// >>> design/rdac_pkg.sv
// Operation
// RL1 - selector 1001 writes channel A code
// RL2 - selector 1010 writes channel B code
// RL3 - code field is bits 11 to 3
// RL4 - other selectors never update a code
// RL5 - host drives low three bits zero
// RL6 - default code is 1FF, 2.5 V
// RL7 - host never programs codes 064 down to 000
// RL8 - host trims around tabulated code, five either side
// RL9 - channel codes held independently
`default_nettype none
package rdac_pkg;
	localparam int WORD_W = 16;
	localparam int CODE_W = 9;
	localparam int SEL_HI = 15;
	localparam int SEL_LO = 12;
	localparam int CODE_HI = 11;
	localparam int CODE_LO = 3;
	localparam int RSV_HI = 2;
	localparam logic [3:0] SEL_WR_A = 4'h9;
	localparam logic [3:0] SEL_WR_B = 4'ha;
	localparam logic [CODE_W-1:0] CODE_DEFAULT = 9'h1ff;
	localparam logic [CODE_W-1:0] CODE_FORBID_MAX = 9'h064;
	localparam logic [2:0] RSV_VALUE = 3'h0;
	// host register offsets over apb
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_CODE_A = 12'h008;
	localparam logic [11:0] OFS_CODE_B = 12'h00c;
	localparam logic [31:0] APB_ZERO = 32'h0000_0000;
	localparam logic [31:0] APB_BAD = 32'hdead_beef;
	typedef enum logic [2:0]
	{
		RDAC_IDLE = 3'h1,
		RDAC_SEND = 3'h2,
		RDAC_DONE = 3'h4
	} rdac_state_t;
endpackage : rdac_pkg
`default_nettype wire

// >>> design/rdac_if.sv
`timescale 1ns/1ps
`default_nettype none
// word carrier between host end and device end
interface rdac_if;
	logic [15:0] ref_level_word;
	logic        word_valid;
	modport host (output ref_level_word, output word_valid);
	modport dev (input ref_level_word, input word_valid);
endinterface : rdac_if
`default_nettype wire

// >>> design/rdac_dev.sv
`timescale 1ns/1ps
`default_nettype none
module rdac_dev
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	rdac_if.dev                         link,
	output var logic [rdac_pkg::CODE_W-1:0] channel_a_ref_code,
	output var logic [rdac_pkg::CODE_W-1:0] channel_b_ref_code
);
	import rdac_pkg::*;
	logic [3:0]        target_select_nibble;
	logic [CODE_W-1:0] code_field;
	// split the word into selector and code
	assign target_select_nibble = link.ref_level_word[SEL_HI:SEL_LO];
	assign code_field = link.ref_level_word[CODE_HI:CODE_LO]; // RL3
	// channel a code, defaults to 2.5 v
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			channel_a_ref_code <= CODE_DEFAULT; // RL6
		else if (link.word_valid && target_select_nibble == SEL_WR_A) // RL1 RL4
			channel_a_ref_code <= code_field; // RL9
	end
	// channel b code, independent of a
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			channel_b_ref_code <= CODE_DEFAULT; // RL6
		else if (link.word_valid && target_select_nibble == SEL_WR_B) // RL2 RL4
			channel_b_ref_code <= code_field; // RL9
	end
endmodule : rdac_dev
`default_nettype wire

// >>> design/rdac_host.sv
`timescale 1ns/1ps
`default_nettype none
// host end: takes words over apb, checks them, sends legal ones written while idle on the link
module rdac_host
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave side
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var logic  [31:0] prdata,
	output var logic         pready,
	output var logic         pslverr,
	// word link to the device end
	rdac_if.host             link
);
	import rdac_pkg::*;

	// sequencer and register state
	rdac_state_t       state_r;
	rdac_state_t       state_nxt;
	logic [15:0]       word_r;
	logic              word_valid_r;
	logic              busy_r;
	logic              reject_r;
	logic [CODE_W-1:0] shadow_a_r;
	logic [CODE_W-1:0] shadow_b_r;

	// bus phase decode and word checks
	logic              setup;
	logic              acc;
	logic              wr_ctrl;
	logic              sel_legal;
	logic              rsv_clear;
	logic              code_allowed;
	logic              word_ok;
	logic              take_word;
	logic              drop_word;
	logic              send_a;
	logic              send_b;
	logic [31:0]       rd_word;
	logic              rd_miss;

	// setup cycle and the access edge that completes a transfer
	assign setup = psel && !penable;
	assign acc = psel && penable && pready;

	// a control write takes effect only at the edge that completes it
	// the write data is still held then, so the checks below see it
	assign wr_ctrl = acc && pwrite && paddr == OFS_CTRL;

	// only the two channel selectors name a code write
	assign sel_legal = pwdata[SEL_HI:SEL_LO] == SEL_WR_A // RL1
		|| pwdata[SEL_HI:SEL_LO] == SEL_WR_B; // RL2
	// reserved bits must go out as zero
	assign rsv_clear = pwdata[RSV_HI:0] == RSV_VALUE; // RL5
	// codes at or below the forbidden ceiling never leave the host
	assign code_allowed = pwdata[CODE_HI:CODE_LO] > CODE_FORBID_MAX; // RL7
	assign word_ok = sel_legal && rsv_clear && code_allowed;

	// words are taken only while idle; a write while busy is dropped without a flag
	// software polls busy before the next control write
	assign take_word = wr_ctrl && word_ok && state_r == RDAC_IDLE;
	assign drop_word = wr_ctrl && !word_ok && state_r == RDAC_IDLE;

	// which host copy follows the word as it goes out
	assign send_a = state_r == RDAC_SEND && word_r[SEL_HI:SEL_LO] == SEL_WR_A;
	assign send_b = state_r == RDAC_SEND && word_r[SEL_HI:SEL_LO] == SEL_WR_B;

	// zero wait states: pready follows the setup cycle by one clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= setup;
	end

	// read mux, decoded from the address
	always_comb
	begin
		rd_word = APB_ZERO;
		rd_miss = 1'b0;
		case (paddr)
			OFS_CTRL: rd_word = {APB_ZERO[31:WORD_W], word_r};
			OFS_STAT: rd_word = {APB_ZERO[31:2], reject_r, busy_r};
			OFS_CODE_A: rd_word = {APB_ZERO[31:CODE_W], shadow_a_r};
			OFS_CODE_B: rd_word = {APB_ZERO[31:CODE_W], shadow_b_r};
			default:
			begin
				rd_word = APB_BAD;
				rd_miss = 1'b1;
			end
		endcase
	end

	// read data is caught at setup and stands until the next setup
	// so status reads show what stood at the setup edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= APB_ZERO;
		else if (setup)
			prdata <= rd_word;
	end

	// error flag for unmapped addresses, caught with the read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else if (setup)
			pslverr <= rd_miss;
	end

	// next state of the send sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			RDAC_IDLE:
			begin
				if (take_word)
					state_nxt = RDAC_SEND;
			end
			RDAC_SEND: state_nxt = RDAC_DONE;
			RDAC_DONE: state_nxt = RDAC_IDLE;
			default: state_nxt = RDAC_IDLE;
		endcase
	end

	// sequencer state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= RDAC_IDLE;
		else
			state_r <= state_nxt;
	end

	// last accepted word, held on the link between sends
	// the device only looks at it while the valid pulse stands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			word_r <= 16'h0000;
		else if (take_word)
			word_r <= pwdata[WORD_W-1:0];
	end

	// one valid pulse per accepted word, registered from the send state so it stands in the done state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			word_valid_r <= 1'b0;
		else
			word_valid_r <= state_r == RDAC_SEND;
	end

	// busy from acceptance until the word has reached the device
	// software must wait for it to clear before the next control write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_r <= 1'b0;
		else if (take_word)
			busy_r <= 1'b1;
		else if (state_r == RDAC_DONE)
			busy_r <= 1'b0;
	end

	// reject flag: set by a refused word, cleared by an accepted one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reject_r <= 1'b0;
		else if (take_word)
			reject_r <= 1'b0;
		else if (drop_word)
			reject_r <= 1'b1; // RL4 RL5 RL7
	end

	// host copy of channel a, updated as the word goes out
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shadow_a_r <= CODE_DEFAULT;
		else if (send_a)
			shadow_a_r <= word_r[CODE_HI:CODE_LO]; // RL1
	end

	// host copy of channel b
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shadow_b_r <= CODE_DEFAULT;
		else if (send_b)
			shadow_b_r <= word_r[CODE_HI:CODE_LO]; // RL2
	end

	// drive the link from registers
	assign link.ref_level_word = word_r;
	assign link.word_valid = word_valid_r;
endmodule : rdac_host
`default_nettype wire

// >>> test/rdac_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rdac_asserts
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [15:0] ref_level_word,
	input wire logic        word_valid,
	input wire logic [8:0]  channel_a_ref_code,
	input wire logic [8:0]  channel_b_ref_code
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// word pulses that target each channel
	wire logic sel_a = word_valid && ref_level_word[15:12] == 4'h9;
	wire logic sel_b = word_valid && ref_level_word[15:12] == 4'ha;
	a_store_chan_a: assert property (sel_a |=> channel_a_ref_code == $past(ref_level_word[11:3]))
		else $error("channel a code not stored");
	a_store_chan_b: assert property (sel_b |=> channel_b_ref_code == $past(ref_level_word[11:3]))
		else $error("channel b code not stored");
	a_keep_chan_a: assert property (!sel_a |=> $stable(channel_a_ref_code))
		else $error("channel a code changed");
	a_keep_chan_b: assert property (!sel_b |=> $stable(channel_b_ref_code))
		else $error("channel b code changed");
	a_reserved_zero: assert property (word_valid |-> ref_level_word[2:0] == 3'h0)
		else $error("reserved bits sent nonzero");
	a_code_legal: assert property (word_valid |-> ref_level_word[11:3] > 9'h064)
		else $error("forbidden code sent");
	a_valid_pulse: assert property (word_valid |=> !word_valid)
		else $error("valid longer than one cycle");
	a_default_code: assert property ($rose(presetn) |-> channel_a_ref_code == 9'h1ff && channel_b_ref_code == 9'h1ff)
		else $error("codes not at default");
	c_write_a: cover property (sel_a);
	c_write_b: cover property (sel_b);
	c_a_then_b: cover property (sel_a ##[1:40] sel_b);
endmodule : rdac_asserts
`default_nettype wire

// >>> test/test_reference_dac_code_register.sv
`timescale 1ns/1ps
`default_nettype none
module test_reference_dac_code_register;
	import rdac_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [8:0] channel_a_ref_code, channel_b_ref_code, ea = 9'h1ff, eb = 9'h1ff;
	int err_count = 0, comparisons = 0;
	logic err_seen = 1'b0;
	rdac_if link ();
	rdac_host rdac_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	rdac_dev rdac_dev_inst (.pclk(pclk), .presetn(presetn), .link(link),
		.channel_a_ref_code(channel_a_ref_code), .channel_b_ref_code(channel_b_ref_code));
	rdac_asserts rdac_asserts_inst (.pclk(pclk), .presetn(presetn), .ref_level_word(link.ref_level_word),
		.word_valid(link.word_valid), .channel_a_ref_code(channel_a_ref_code), .channel_b_ref_code(channel_b_ref_code));
	initial forever #20 pclk = ~pclk;
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin err_count++; $display("[ERR] %s exp %h got %h", s, e, g); end
	endtask : chk
	// one apb transfer: setup, access held until pready at a rising edge, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			report_and_stop();
		end
		q = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// send one word, wait for idle, compare flags, codes and host copies
	task automatic put(input logic [3:0] s, input logic [8:0] c, input logic [2:0] r, input logic ok);
		logic [31:0] q;
		int n;
		n = 0;
		apb(1'b1, OFS_CTRL, {16'h0000, s, c, r}, q);
		do
		begin
			apb(1'b0, OFS_STAT, APB_ZERO, q);
			n++;
		end
		while (q[0] !== 1'b0 && n < 10);
		if (q[0] !== 1'b0)
		begin
			err_count++;
			report_and_stop();
		end
		chk("reject", !ok, q[1]);
		if (ok && s == SEL_WR_A)
			ea = c;
		if (ok && s == SEL_WR_B)
			eb = c;
		chk("code_a", ea, channel_a_ref_code);
		chk("code_b", eb, channel_b_ref_code);
		apb(1'b0, OFS_CODE_A, APB_ZERO, q);
		chk("shadow_a", ea, q);
		apb(1'b0, OFS_CODE_B, APB_ZERO, q);
		chk("shadow_b", eb, q);
	endtask : put
	// values after reset, a foreign selector, an unmapped address
	task automatic t_reset;
		logic [31:0] q;
		put(4'h0, 9'h1ff, 3'h0, 1'b0);
		apb(1'b0, 12'h010, APB_ZERO, q);
		chk("unmapped", APB_BAD, q);
		chk("pslverr", 1'b1, err_seen);
		$display("test reset done");
	endtask : t_reset
	// legal words to both channels, read back of the control word
	task automatic t_writes;
		logic [31:0] q;
		put(SEL_WR_A, 9'h1d7, 3'h0, 1'b1);
		apb(1'b0, OFS_CTRL, APB_ZERO, q);
		chk("ctrl_word", {16'h0000, SEL_WR_A, 9'h1d7, RSV_VALUE}, q);
		chk("pslverr", 1'b0, err_seen);
		put(SEL_WR_B, 9'h069, 3'h0, 1'b1);
		put(SEL_WR_A, 9'h065, 3'h0, 1'b1);
		$display("test writes done");
	endtask : t_writes
	task automatic t_refuse;
		put(4'h8, 9'h100, 3'h0, 1'b0);
		put(SEL_WR_B, 9'h100, 3'h4, 1'b0);
		put(SEL_WR_A, 9'h064, 3'h0, 1'b0);
		$display("test refusals done");
	endtask : t_refuse
	// trim around a tabulated code, five codes either side, ending on it
	task automatic t_trim;
		logic [8:0] c;
		for (int k = 0; k < 11; k++)
		begin
			c = 9'h1d2 + 9'(k);
			put(SEL_WR_B, c, 3'h0, 1'b1);
		end
		put(SEL_WR_B, 9'h1d7, 3'h0, 1'b1);
		$display("test trim done");
	endtask : t_trim
	// reset in mid-run brings both codes, copies and flags back to defaults
	task automatic t_midreset;
		logic [31:0] q;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		ea = CODE_DEFAULT;
		eb = CODE_DEFAULT;
		chk("code_a", ea, channel_a_ref_code);
		chk("code_b", eb, channel_b_ref_code);
		apb(1'b0, OFS_CODE_A, APB_ZERO, q);
		chk("shadow_a", ea, q);
		apb(1'b0, OFS_CODE_B, APB_ZERO, q);
		chk("shadow_b", eb, q);
		apb(1'b0, OFS_STAT, APB_ZERO, q);
		chk("status", APB_ZERO, q);
		$display("test mid-run reset done");
	endtask : t_midreset
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_writes();
		t_refuse();
		t_trim();
		t_midreset();
		report_and_stop();
	end
endmodule : test_reference_dac_code_register
`default_nettype wire
